/* rtl/isq_top.v */
// in-system-programming sequencer: registers on classic wishbone, idle-driven flash operations,
// a16 banking pin choice and the software reset sequence
// assumes: core raises cpu_idle_enter for one cycle when it executes an idle entry,
// timer_expire pulses when the software timer runs out, flash arrays answer with fl_ack
//
// Behaviour
// - 0x83 plus idle, timer expiry restarts application
// - address high and low form byte address
// - single-byte data goes through the data register
// - bank bit picks application bank 1 or 0
// - target bit picks application or loader flash
// - codes erase, program, read; enable bits checked
// - banking enable lets a port-1 pin drive a16
// - three-bit field picks a16 pin, default seven
// - isp enable makes idle run the operation
// - soft reset bit resets device, self-clears
// - loader select routes fetch; status shows region
//
// Local design decision: the Wishbone interface to the registers.
`include "isq_defines.vh"

module isq_top #(
    parameter AW = 16,
    parameter DW = 8,
    parameter ADR_W = 10,
    parameter PINS = 8
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // core handshake
    input wire cpu_idle_enter,
    input wire timer_expire,
    output wire cpu_idle_hold,
    output reg cpu_resume_r,
    output reg soft_reset_out_r,
    output wire loader_fetch_active,
    // banking
    input wire [PINS-1:0] port1_pins,
    output wire app_a16,
    // flash array port
    output wire fl_erase,
    output wire fl_program,
    output wire fl_read,
    output wire [1:0] fl_array,
    output wire [AW-1:0] fl_addr,
    output wire [DW-1:0] fl_wdata,
    output wire flash_read_enable_n,
    output wire flash_select_n,
    input wire fl_ack,
    input wire [DW-1:0] fl_rdata
);

    localparam ST_IDLE = 4'b0001;
    localparam ST_RUN = 4'b0010;
    localparam ST_WAKE = 4'b0100;
    localparam ST_SRWAIT = 4'b1000;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [DW-1:0] chip_control_r;
    reg [DW-1:0] rom_bank_control_r;
    reg [DW-1:0] isp_address_low_r;
    reg [DW-1:0] isp_address_high_r;
    reg [DW-1:0] isp_data_reg_r;
    reg [DW-1:0] isp_operation_control_r;
    reg loader_exec_status_r;
    reg sr_armed_r;
    reg [DW-1:0] rd_byte;
    reg [2:0] kind;
    reg op_ok;

    wire bus_req;
    wire wr_en;
    wire [`ISQ_IDX_W-1:0] idx;
    wire isp_enable;
    wire [3:0] op_code;
    wire [1:0] array_sel;
    wire [AW-1:0] isp_addr;
    wire op_start;
    wire op_done;
    wire [DW-1:0] op_rdata;
    wire sr_immediate;

    // a request is taken once; ack falls the cycle after it rose
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[ADR_W-1:2];

    assign isp_enable = chip_control_r[`ISQ_CHIP_ISP_ENABLE];
    assign op_code = isp_operation_control_r[`ISQ_OP_CODE_HI:`ISQ_OP_CODE_LO];

    assign isp_addr = {isp_address_high_r, isp_address_low_r};

    // array from bank and target bits
    assign array_sel = isp_operation_control_r[`ISQ_OP_TARGET_ARRAY_SEL] ? `ISQ_ARR_LOADER :
                       (isp_operation_control_r[`ISQ_OP_BANK] ? `ISQ_ARR_APP1 : `ISQ_ARR_APP0);

    always @* begin
        kind = 3'b000;
        op_ok = 1'b0;
        case (op_code)
            `ISQ_CODE_ERASE: begin
                kind = `ISQ_KIND_ERASE;
                op_ok = isp_operation_control_r[`ISQ_OP_READ_ENABLE_N];
            end
            `ISQ_CODE_PROGRAM: begin
                kind = `ISQ_KIND_PROGRAM;
                op_ok = isp_operation_control_r[`ISQ_OP_READ_ENABLE_N];
            end
            `ISQ_CODE_READ: begin
                kind = `ISQ_KIND_READ;
                op_ok = ~isp_operation_control_r[`ISQ_OP_READ_ENABLE_N];
            end
            default: begin
                kind = 3'b000;
                op_ok = 1'b0;
            end
        endcase
        // select bit must be low for any operation
        op_ok = op_ok & ~isp_operation_control_r[`ISQ_OP_SELECT_N];
    end

    // idle starts an operation only in isp mode
    assign op_start = state_r[0] & cpu_idle_enter & isp_enable & op_ok & ~sr_armed_r;

    // hold the core while the operation runs
    assign cpu_idle_hold = state_r[1] | state_r[2] | state_r[3];

    // fetch routing follows the executing region
    assign loader_fetch_active = loader_exec_status_r;

    // soft reset written alone acts at once
    assign sr_immediate = wr_en && (idx == `ISQ_IDX_CHIP_CONTROL) &&
                          wb_dat_i[`ISQ_CHIP_SOFT_RESET] &&
                          (wb_dat_i[DW-1:0] != `ISQ_CHIP_SOFT_RESET_SEQ);

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (sr_armed_r && cpu_idle_enter) begin
                    state_nxt = ST_SRWAIT;
                end else if (op_start) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (op_done) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                state_nxt = ST_IDLE;
            end
            ST_SRWAIT: begin
                if (timer_expire) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            cpu_resume_r <= 1'b0;
            soft_reset_out_r <= 1'b0;
            sr_armed_r <= 1'b0;
            loader_exec_status_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // wake pulse comes after read data is already stored
            cpu_resume_r <= state_r[2];
            soft_reset_out_r <= 1'b0;
            // arm on 0x83, reset when timer ends idle
            if (wr_en && (idx == `ISQ_IDX_CHIP_CONTROL) &&
                (wb_dat_i[DW-1:0] == `ISQ_CHIP_SOFT_RESET_SEQ)) begin
                sr_armed_r <= 1'b1;
            end
            if (state_r[3] && timer_expire) begin
                sr_armed_r <= 1'b0;
                soft_reset_out_r <= 1'b1;
                loader_exec_status_r <= 1'b0;
            end
            // immediate soft reset, region from loader select
            if (sr_immediate) begin
                sr_armed_r <= 1'b0;
                soft_reset_out_r <= 1'b1;
                loader_exec_status_r <= wb_dat_i[`ISQ_CHIP_LOADER_FETCH_SEL];
            end
        end
    end

    // register writes
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            chip_control_r <= `ISQ_CHIP_RESET;
            rom_bank_control_r <= `ISQ_ROM_RESET;
            isp_address_low_r <= `ISQ_BYTE_RESET;
            isp_address_high_r <= `ISQ_BYTE_RESET;
            isp_data_reg_r <= `ISQ_BYTE_RESET;
            isp_operation_control_r <= `ISQ_OP_RESET;
        end else begin
            if (wr_en) begin
                case (idx)
                    `ISQ_IDX_CHIP_CONTROL: begin
                        chip_control_r <= wb_dat_i[DW-1:0] & `ISQ_CHIP_WMASK;
                    end
                    `ISQ_IDX_ROM_BANK_CONTROL: begin
                        rom_bank_control_r <= wb_dat_i[DW-1:0] & `ISQ_ROM_WMASK;
                    end
                    `ISQ_IDX_ISP_ADDRESS_LOW: begin
                        isp_address_low_r <= wb_dat_i[DW-1:0];
                    end
                    `ISQ_IDX_ISP_ADDRESS_HIGH: begin
                        isp_address_high_r <= wb_dat_i[DW-1:0];
                    end
                    `ISQ_IDX_ISP_DATA_REG: begin
                        isp_data_reg_r <= wb_dat_i[DW-1:0];
                    end
                    `ISQ_IDX_ISP_OPERATION_CONTROL: begin
                        isp_operation_control_r <= wb_dat_i[DW-1:0];
                    end
                    default: begin
                    end
                endcase
            end
            // read result lands in data register, beats a bus write
            if (state_r[1] && op_done && isp_operation_control_r[`ISQ_OP_CODE_HI:`ISQ_OP_CODE_LO] ==
                `ISQ_CODE_READ) begin
                isp_data_reg_r <= op_rdata;
            end
            // soft reset pulse clears isp enable and loader select; the exec status bit read back is not cleared here
            if (soft_reset_out_r) begin
                chip_control_r <= `ISQ_CHIP_RESET;
            end
        end
    end

    always @* begin
        rd_byte = `ISQ_BYTE_RESET;
        case (idx)
            `ISQ_IDX_CHIP_CONTROL: begin
                rd_byte = chip_control_r;
                rd_byte[`ISQ_CHIP_LOADER_EXEC_STATUS] = loader_exec_status_r;
                rd_byte[`ISQ_CHIP_SOFT_RESET] = sr_armed_r;
            end
            `ISQ_IDX_ROM_BANK_CONTROL: begin
                rd_byte = rom_bank_control_r;
            end
            `ISQ_IDX_ISP_ADDRESS_LOW: begin
                rd_byte = isp_address_low_r;
            end
            `ISQ_IDX_ISP_ADDRESS_HIGH: begin
                rd_byte = isp_address_high_r;
            end
            `ISQ_IDX_ISP_DATA_REG: begin
                rd_byte = isp_data_reg_r;
            end
            `ISQ_IDX_ISP_OPERATION_CONTROL: begin
                rd_byte = isp_operation_control_r;
            end
            default: begin
                rd_byte = `ISQ_BYTE_RESET;
            end
        endcase
    end

    // unmapped addresses still ack and read zero
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `ISQ_WORD_ZERO;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= {{(32-DW){1'b0}}, rd_byte};
            end
        end
    end

    // program data taken from the data register
    isq_flash_if #(
        .AW(AW),
        .DW(DW)
    ) u_flash_if (
        .clk(clk),
        .rst(rst),
        .start(op_start),
        .kind(kind),
        .array_sel(array_sel),
        .addr(isp_addr),
        .wdata(isp_data_reg_r),
        .read_enable_n(isp_operation_control_r[`ISQ_OP_READ_ENABLE_N]),
        .select_n(isp_operation_control_r[`ISQ_OP_SELECT_N]),
        .done(op_done),
        .rdata_r(op_rdata),
        .fl_erase_r(fl_erase),
        .fl_program_r(fl_program),
        .fl_read_r(fl_read),
        .fl_array_r(fl_array),
        .fl_addr_r(fl_addr),
        .fl_wdata_r(fl_wdata),
        .flash_read_enable_n_r(flash_read_enable_n),
        .flash_select_n_r(flash_select_n),
        .fl_ack(fl_ack),
        .fl_rdata(fl_rdata)
    );

    isq_a16_mux #(
        .PINS(PINS),
        .SEL_W(3)
    ) u_a16 (
        .clk(clk),
        .rst(rst),
        .banking_enable(rom_bank_control_r[`ISQ_ROM_BANKING_ENABLE]),
        .a16_pin_select(rom_bank_control_r[`ISQ_ROM_PIN_SEL_HI:`ISQ_ROM_PIN_SEL_LO]),
        .port1_pins(port1_pins),
        .a16_r(app_a16)
    );

endmodule // isq_top

/* rtl/isq_defines.vh */
// constants of the flash programming sequencer: register indices, field positions, codes
// assumes: included by bare name from every design file of the block
`ifndef ISQ_DEFINES_VH
`define ISQ_DEFINES_VH

// register indices; byte address on the bus is four times the index
`define ISQ_IDX_W 8
`define ISQ_IDX_CHIP_CONTROL 8'h9F
`define ISQ_IDX_ROM_BANK_CONTROL 8'hAB
`define ISQ_IDX_ISP_ADDRESS_LOW 8'hAC
`define ISQ_IDX_ISP_ADDRESS_HIGH 8'hAD
`define ISQ_IDX_ISP_DATA_REG 8'hAE
`define ISQ_IDX_ISP_OPERATION_CONTROL 8'hAF

// chip_control fields
`define ISQ_CHIP_SOFT_RESET 7
`define ISQ_CHIP_LOADER_EXEC_STATUS 2
`define ISQ_CHIP_LOADER_FETCH_SEL 1
`define ISQ_CHIP_ISP_ENABLE 0
`define ISQ_CHIP_RESET 8'h00
`define ISQ_CHIP_SOFT_RESET_SEQ 8'h83
`define ISQ_CHIP_WMASK 8'h03

// rom_bank_control fields
`define ISQ_ROM_BANKING_ENABLE 3
`define ISQ_ROM_PIN_SEL_HI 2
`define ISQ_ROM_PIN_SEL_LO 0
`define ISQ_ROM_RESET 8'h07
`define ISQ_ROM_WMASK 8'h0F

// isp_operation_control fields
`define ISQ_OP_BANK 7
`define ISQ_OP_TARGET_ARRAY_SEL 6
`define ISQ_OP_READ_ENABLE_N 5
`define ISQ_OP_SELECT_N 4
`define ISQ_OP_CODE_HI 3
`define ISQ_OP_CODE_LO 0
`define ISQ_OP_RESET 8'h00

// operation codes
`define ISQ_CODE_READ 4'h0
`define ISQ_CODE_PROGRAM 4'h1
`define ISQ_CODE_ERASE 4'h2

// flash array selection on the array port
`define ISQ_ARR_APP0 2'h0
`define ISQ_ARR_APP1 2'h1
`define ISQ_ARR_LOADER 2'h2

// operation kinds, one-hot
`define ISQ_KIND_ERASE 3'h1
`define ISQ_KIND_PROGRAM 3'h2
`define ISQ_KIND_READ 3'h4

`define ISQ_BYTE_RESET 8'h00
`define ISQ_WORD_ZERO 32'h00000000

`endif

/* rtl/isq_a16_mux.v */
// picks the port-1 pin that serves as application address line a16
// assumes: pin levels synchronous to clk
`include "isq_defines.vh"

module isq_a16_mux #(
    parameter PINS = 8,
    parameter SEL_W = 3
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire banking_enable,
    input wire [SEL_W-1:0] a16_pin_select,
    input wire [PINS-1:0] port1_pins,
    // result
    output reg a16_r
);

    // banking off pins a16 low, so only bank 0 is reachable
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            a16_r <= 1'b0;
        end else begin
            a16_r <= banking_enable & port1_pins[a16_pin_select];
        end
    end

endmodule // isq_a16_mux

/* rtl/isq_flash_if.v */
// drives one erase, program or read request to the flash arrays and waits for their ack
// assumes: the array holds fl_ack high for one cycle when the request is finished
`include "isq_defines.vh"

module isq_flash_if #(
    parameter AW = 16,
    parameter DW = 8
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // command from the sequencer
    input wire start,
    input wire [2:0] kind,
    input wire [1:0] array_sel,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    input wire read_enable_n,
    input wire select_n,
    output wire done,
    output reg [DW-1:0] rdata_r,
    // flash array port
    output reg fl_erase_r,
    output reg fl_program_r,
    output reg fl_read_r,
    output reg [1:0] fl_array_r,
    output reg [AW-1:0] fl_addr_r,
    output reg [DW-1:0] fl_wdata_r,
    output reg flash_read_enable_n_r,
    output reg flash_select_n_r,
    input wire fl_ack,
    input wire [DW-1:0] fl_rdata
);

    localparam ST_IDLE = 3'b001;
    localparam ST_BUSY = 3'b010;
    localparam ST_DONE = 3'b100;

    reg [2:0] state_r;

    assign done = state_r[2];

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            rdata_r <= `ISQ_BYTE_RESET;
            fl_erase_r <= 1'b0;
            fl_program_r <= 1'b0;
            fl_read_r <= 1'b0;
            fl_array_r <= `ISQ_ARR_APP0;
            fl_addr_r <= {AW{1'b0}};
            fl_wdata_r <= {DW{1'b0}};
            flash_read_enable_n_r <= 1'b1;
            flash_select_n_r <= 1'b1;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        fl_erase_r <= kind[0];
                        fl_program_r <= kind[1];
                        fl_read_r <= kind[2];
                        fl_array_r <= array_sel;
                        fl_addr_r <= addr;
                        fl_wdata_r <= wdata;
                        flash_read_enable_n_r <= read_enable_n;
                        flash_select_n_r <= select_n;
                        state_r <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (fl_ack) begin
                        if (fl_read_r) begin
                            rdata_r <= fl_rdata;
                        end
                        fl_erase_r <= 1'b0;
                        fl_program_r <= 1'b0;
                        fl_read_r <= 1'b0;
                        flash_read_enable_n_r <= 1'b1;
                        flash_select_n_r <= 1'b1;
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // isq_flash_if

/* bench/isq_flash_model.sv */
// behavioural flash arrays: application banks 0 and 1 and the loader bank
// assumes: one request at a time, strobes held until fl_ack is seen
module isq_flash_model (
    // clock and reset
    input wire clk,
    input wire rst,
    // request
    input wire fl_erase,
    input wire fl_program,
    input wire fl_read,
    input wire [1:0] fl_array,
    input wire [15:0] fl_addr,
    input wire [7:0] fl_wdata,
    input wire slow,
    // answer
    output logic fl_ack,
    output logic [7:0] fl_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [4][65536];
    int cnt;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fl_ack <= 1'b0;
            fl_rdata <= 8'h00;
            cnt <= 0;
        end else begin
            fl_ack <= 1'b0;
            // data is only valid in the answer cycle
            fl_rdata <= ~fl_rdata;
            if ((fl_erase || fl_program || fl_read) && !fl_ack) begin
                if (cnt < (slow ? 5 : 0)) begin
                    cnt <= cnt + 1;
                end else begin
                    cnt <= 0;
                    fl_ack <= 1'b1;
                    if (fl_erase) begin
                        for (int k = 0; k < 65536; k++) begin
                            mem[fl_array][k] = 8'hFF;
                        end
                    end
                    if (fl_program) begin
                        mem[fl_array][fl_addr] = mem[fl_array][fl_addr] & fl_wdata;
                    end
                    if (fl_read) begin
                        fl_rdata <= mem[fl_array][fl_addr];
                    end
                end
            end
        end
    end
endmodule // isq_flash_model

/* bench/isq_top_assertions.sv */
// port checks of the flash programming sequencer
// assumes: bound into isq_top, one clock, asynchronous active-high reset
module isq_top_assertions (
    // clock and reset
    input wire clk,
    input wire rst,
    // bus
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // core handshake
    input wire cpu_idle_enter,
    input wire cpu_idle_hold,
    input wire cpu_resume_r,
    input wire soft_reset_out_r,
    // flash port
    input wire fl_erase,
    input wire fl_program,
    input wire fl_read,
    input wire [1:0] fl_array,
    input wire flash_read_enable_n,
    input wire flash_select_n,
    input wire fl_ack
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire fl_any = fl_erase | fl_program | fl_read;
    property p_bus_ack;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_bus_ack: assert property (p_bus_ack)
        else $error("bus ack not a single pulse");
    property p_take;
        $rose(fl_any) |-> $past(cpu_idle_enter);
    endproperty
    a_take: assert property (p_take)
        else $error("flash request without idle entry");
    property p_read_bits;
        fl_read |-> !flash_read_enable_n && !flash_select_n;
    endproperty
    a_read_bits: assert property (p_read_bits)
        else $error("read enable bits wrong");
    property p_write_bits;
        fl_erase || fl_program |-> flash_read_enable_n && !flash_select_n;
    endproperty
    a_write_bits: assert property (p_write_bits)
        else $error("erase or program enable bits wrong");
    property p_strobe_hold;
        fl_any && !fl_ack |=> fl_any && $stable(fl_array);
    endproperty
    a_strobe_hold: assert property (p_strobe_hold)
        else $error("request dropped before ack");
    property p_resume;
        fl_any && fl_ack |=> cpu_idle_hold [*2] ##1 cpu_resume_r && !cpu_idle_hold;
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume not three cycles after ack");
    property p_hold;
        fl_any |-> cpu_idle_hold;
    endproperty
    a_hold: assert property (p_hold)
        else $error("core not held during flash operation");
    property p_array;
        fl_any |-> fl_array != 2'h3;
    endproperty
    a_array: assert property (p_array)
        else $error("no such flash array");
    property p_reset_pulse;
        soft_reset_out_r |=> !soft_reset_out_r;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("soft reset longer than one cycle");
endmodule // isq_top_assertions

bind isq_top isq_top_assertions chk_u (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .cpu_idle_enter(cpu_idle_enter), .cpu_idle_hold(cpu_idle_hold),
    .cpu_resume_r(cpu_resume_r), .soft_reset_out_r(soft_reset_out_r), .fl_erase(fl_erase),
    .fl_program(fl_program), .fl_read(fl_read), .fl_array(fl_array),
    .flash_read_enable_n(flash_read_enable_n), .flash_select_n(flash_select_n), .fl_ack(fl_ack));

/* bench/isq_top_tb.sv */
// self-checking bench of the flash programming sequencer
// assumes: isq_top with default parameters, behavioural flash on the array port
module isq_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, cyc, stb, we, idle, tmo, slow;
    logic [9:0] adr;
    logic [31:0] din;
    logic [7:0] pins, q;
    logic [3:0] sel;
    wire [31:0] dout;
    wire ack, hold, resume, srst, ldr, a16, fe, fp, fr, ren_n, sel_n, fack;
    wire [1:0] farr;
    wire [15:0] fadr;
    wire [7:0] fwd, frd;
    int errors, checked, cycles, n_res, n_rst;
    logic [1:0] seen_arr;
    logic [15:0] seen_adr;
    typedef struct {logic [7:0] op; logic [15:0] a; logic [7:0] d; logic [1:0] arr; logic [7:0] exp; logic sl;} isq_row_t;
    isq_row_t rows [10] = '{'{8'h62, 16'h0000, 8'h00, 2'h2, 8'h00, 1'b0}, '{8'h22, 16'h0000, 8'h00, 2'h0, 8'h00, 1'b1},
        '{8'hA2, 16'h0000, 8'h00, 2'h1, 8'h00, 1'b0}, '{8'h61, 16'h0012, 8'h5A, 2'h2, 8'h5A, 1'b0},
        '{8'hA1, 16'hFFFF, 8'hC3, 2'h1, 8'hC3, 1'b1}, '{8'h21, 16'h0100, 8'h3C, 2'h0, 8'h3C, 1'b0},
        '{8'h40, 16'h0012, 8'h00, 2'h2, 8'h5A, 1'b0}, '{8'h80, 16'hFFFF, 8'h00, 2'h1, 8'hC3, 1'b1},
        '{8'h00, 16'h0100, 8'h11, 2'h0, 8'h3C, 1'b0}, '{8'h00, 16'hFFFF, 8'h00, 2'h0, 8'hFF, 1'b0}};
    logic [7:0] bad [3] = '{8'h40, 8'h01, 8'h32};

    isq_top dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(din), .wb_dat_o(dout), .wb_ack_o(ack), .cpu_idle_enter(idle),
        .timer_expire(tmo), .cpu_idle_hold(hold), .cpu_resume_r(resume), .soft_reset_out_r(srst),
        .loader_fetch_active(ldr), .port1_pins(pins), .app_a16(a16), .fl_erase(fe), .fl_program(fp),
        .fl_read(fr), .fl_array(farr), .fl_addr(fadr), .fl_wdata(fwd), .flash_read_enable_n(ren_n),
        .flash_select_n(sel_n), .fl_ack(fack), .fl_rdata(frd));
    isq_flash_model flash_u (.clk(clk), .rst(rst), .fl_erase(fe), .fl_program(fp), .fl_read(fr),
        .fl_array(farr), .fl_addr(fadr), .fl_wdata(fwd), .slow(slow), .fl_ack(fack), .fl_rdata(frd));

    task automatic summarize;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // call just after a rising edge
    task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d, output logic [7:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        din <= {24'h000000, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = dout[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] r;
        bus(idx, 1'b1, d, r);
    endtask
    // one-cycle pulse on the timer line or on the idle-entry line
    task automatic pulse(input logic timer);
        if (timer) tmo <= 1'b1;
        else idle <= 1'b1;
        @(posedge clk);
        idle <= 1'b0;
        tmo <= 1'b0;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (fe || fp || fr) begin
            seen_arr <= farr;
            seen_adr <= fadr;
        end
        if (resume === 1'b1) n_res <= n_res + 1;
        if (srst === 1'b1) n_rst <= n_rst + 1;
        if (cycles == 20000) begin
            errors++;
            summarize();
        end
    end

    initial begin
        int n0;
        {rst, cyc, stb, we, idle, tmo, slow} = 7'h7F & 7'h40;
        adr = 10'h000;
        din = 32'h00000000;
        pins = 8'h00;
        sel = 4'hF;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(8'h9F, 1'b0, 8'h00, q);
        check(q, 8'h00, "chip control reset");
        bus(8'hAB, 1'b0, 8'h00, q);
        check(q, 8'h07, "bank control reset");
        bus(8'h10, 1'b0, 8'h00, q);
        check(q, 8'h00, "unmapped read");
        wr(8'hAD, 8'hA5);
        bus(8'hAD, 1'b0, 8'h00, q);
        check(q, 8'hA5, "address high");
        sel <= 4'h0;
        wr(8'hAD, 8'h11);
        sel <= 4'hF;
        bus(8'hAD, 1'b0, 8'h00, q);
        check(q, 8'hA5, "lane off write dropped");
        foreach (bad[k]) begin
            wr(8'h9F, (k == 0) ? 8'h00 : 8'h01);
            wr(8'hAF, bad[k]);
            n0 = n_res;
            pulse(1'b0);
            repeat (6) @(posedge clk);
            check(n_res, n0, "ignored idle");
            check(hold, 1'b0, "no hold");
        end
        foreach (rows[i]) begin
            slow <= rows[i].sl;
            wr(8'hAD, rows[i].a[15:8]);
            wr(8'hAC, rows[i].a[7:0]);
            wr(8'hAE, rows[i].d);
            wr(8'hAF, rows[i].op);
            pulse(1'b0);
            do @(posedge clk); while (resume !== 1'b1);
            check(seen_arr, rows[i].arr, "array");
            if (rows[i].op[1:0] != 2'h2) check(seen_adr, rows[i].a, "flash address");
            bus(8'hAE, 1'b0, 8'h00, q);
            check(q, rows[i].exp, "data reg");
        end
        for (int s = 0; s < 8; s++) begin
            wr(8'hAB, 8'h08 | s[7:0]);
            pins <= 8'h01 << s;
            repeat (2) @(posedge clk);
            check(a16, 1'b1, "a16 high");
            pins <= ~(8'h01 << s);
            repeat (2) @(posedge clk);
            check(a16, 1'b0, "a16 low");
        end
        wr(8'hAB, 8'h07);
        pins <= 8'hFF;
        repeat (2) @(posedge clk);
        check(a16, 1'b0, "banking off");
        n0 = n_rst;
        wr(8'h9F, 8'h82);
        repeat (2) @(posedge clk);
        check(n_rst, n0 + 1, "reset pulse");
        check(ldr, 1'b1, "loader fetch");
        bus(8'h9F, 1'b0, 8'h00, q);
        check({q[7], q[2], q[1:0]}, 4'h4, "self clear");
        n0 = n_rst;
        wr(8'h9F, 8'h83);
        repeat (3) @(posedge clk);
        check(n_rst, n0, "armed only");
        pulse(1'b0);
        repeat (2) @(posedge clk);
        check(hold, 1'b1, "held idle");
        pulse(1'b1);
        repeat (2) @(posedge clk);
        check(n_rst, n0 + 1, "timed reset");
        check(ldr, 1'b0, "application fetch");
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(8'hAD, 1'b0, 8'h00, q);
        check(q, 8'h00, "address high after reset");
        summarize();
    end
endmodule // isq_top_tb
